// *** hw/sio_dram_pkg.sv ***
// shared constants, command decode and mode field helpers for the sio dram link
// assumes both ends compile against this one package
package sio_dram_pkg;
  localparam int DATA_W      = 18;
  localparam int PAIR_W      = 2 * DATA_W;
  localparam int ADDR_W      = 20;
  localparam int BANK_W      = 3;
  localparam int MUX_ADDR_W  = 11;
  localparam int MODE_W      = 18;
  localparam int MODE_KEEP_W = 10;
  localparam int COL_W       = 3;
  localparam int IDX_W       = BANK_W + COL_W;
  localparam int MEM_DEPTH   = 1 << IDX_W;
  localparam int BURST_MAX   = 8;
  localparam int LAT_W       = 4;
  localparam int SLOTS       = 10;
  localparam int CNT_W       = 11;
  localparam int IMP_CODE_W  = 8;
  // mode field positions
  localparam int CFG_LSB     = 0;
  localparam int BL_LSB      = 3;
  localparam int MUX_BIT     = 5;
  localparam int LOOP_BIT    = 7;
  localparam int IMP_BIT     = 8;
  localparam int TERM_BIT    = 9;
  localparam logic [1:0] BL2 = 2'h0;
  localparam logic [1:0] BL4 = 2'h1;
  // valid flag lanes {fall, rise}
  localparam logic [1:0] FLAG_OFF  = 2'h0;
  localparam logic [1:0] FLAG_LAST = 2'h1;
  localparam logic [1:0] FLAG_LEAD = 2'h2;
  localparam logic [1:0] FLAG_FULL = 2'h3;
  // link clock cycles, then the nominal impedance code
  localparam logic [CNT_W-1:0] LOOP_LOCK_CYCLES         = 11'h400;
  localparam logic [CNT_W-1:0] MODE_SET_RECOVERY_CYCLES = 11'h006;
  localparam logic [CNT_W-1:0] ROW_CYCLE_CYCLES         = 11'h003;
  localparam logic [CNT_W-1:0] ROW_CYCLE_WR_RD_CYCLES   = 11'h004;
  localparam logic [CNT_W-1:0] IMP_CAL_PERIOD           = 11'h100;
  localparam logic [IMP_CODE_W-1:0] IMP_NOMINAL_OHMS    = 8'h32;

  // four-state base so the command can ride on a wire port
  typedef enum logic [2:0] {CMD_NOP, CMD_READ, CMD_WRITE, CMD_REFRESH, CMD_MODE} cmd_t;

  function automatic cmd_t decode_command(input logic cs_n, input logic we_n,
                                          input logic ref_n);
    if (cs_n) return CMD_NOP;
    unique case ({we_n, ref_n})
      2'h3:    return CMD_READ;
      2'h1:    return CMD_WRITE;
      2'h2:    return CMD_REFRESH;
      default: return CMD_MODE;
    endcase
  endfunction : decode_command

  function automatic logic [1:0] command_pins(input cmd_t cmd);
    unique case (cmd)
      CMD_WRITE:   return 2'h1;
      CMD_REFRESH: return 2'h2;
      CMD_MODE:    return 2'h0;
      default:     return 2'h3;
    endcase
  endfunction : command_pins

  // read latency per configuration; write latency is one more
  function automatic logic [LAT_W-1:0] read_latency(input logic [2:0] cfg);
    unique case (cfg)
      3'h0, 3'h1: return 4'h4;
      3'h2:       return 4'h5;
      3'h3:       return 4'h6;
      3'h4:       return 4'h7;
      default:    return 4'h8;
    endcase
  endfunction : read_latency

  function automatic logic [2:0] burst_pairs(input logic [1:0] bl);
    return (bl == BL2) ? 3'h1 : (bl == BL4) ? 3'h2 : 3'h4;
  endfunction : burst_pairs

  // longer bursts consume fewer column address bits
  function automatic logic [COL_W-1:0] col_base(input logic [COL_W-1:0] col,
                                                input logic [1:0] bl);
    return (bl == BL2) ? {col[2:1], 1'b0} : (bl == BL4) ? {col[2], 2'h0} : 3'h0;
  endfunction : col_base
endpackage : sio_dram_pkg

// *** hw/sio_link_if.sv ***
// link wires between memory controller and dram device
// assumes the controller drives link_clk; data pairs are {fall beat, rise beat}
interface sio_link_if import sio_dram_pkg::*; ();
  logic                  link_clk;
  logic                  cs_n;
  logic                  we_n;
  logic                  ref_n;
  logic [BANK_W-1:0]     bank;
  logic [ADDR_W-1:0]     addr;
  logic [PAIR_W-1:0]     wdata;
  logic [1:0]            write_mask;
  logic [PAIR_W-1:0]     rdata;
  logic                  rdata_oe;
  logic [1:0]            read_valid_flag;

  modport device (input link_clk, cs_n, we_n, ref_n, bank, addr, wdata, write_mask,
                  output rdata, rdata_oe, read_valid_flag);
  modport controller (output link_clk, cs_n, we_n, ref_n, bank, addr, wdata, write_mask,
                      input rdata, rdata_oe, read_valid_flag);
endinterface : sio_link_if

// *** hw/sio_dram_device.sv ***
// dram device end: command decode, operating mode setting, burst write and read
// assumes reset is synchronous to link_clk; write data clock is link_clk itself
module sio_dram_device import sio_dram_pkg::*; (
  sio_link_if.device                  link,
  input  wire logic                   reset,
  input  wire logic [IMP_CODE_W-1:0]  reference_code,
  output logic      [MODE_W-1:0]      mode_setting,
  output logic                        loop_locked,
  output logic      [IMP_CODE_W-1:0]  impedance_code,
  output logic                        read_termination_on,
  output logic                        write_termination_on
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [MODE_W-1:0]     mode;
  logic [MODE_W-1:0]     next_mode;
  logic                  mux_wait;
  logic                  next_mux_wait;
  cmd_t                  cmd;
  cmd_t                  act;
  cmd_t                  mux_cmd;
  cmd_t                  next_mux_cmd;
  logic [BANK_W-1:0]     mux_bank;
  logic [BANK_W-1:0]     next_mux_bank;
  logic [MUX_ADDR_W-1:0] mux_lo;
  logic [MUX_ADDR_W-1:0] next_mux_lo;
  logic [BANK_W-1:0]     act_bank;
  logic [ADDR_W-1:0]     act_addr;
  logic [IDX_W-1:0]      act_idx;
  logic [1:0]            bl;
  logic [LAT_W-1:0]      rl;

  assign cmd     = decode_command(link.cs_n, link.we_n, link.ref_n);
  assign bl      = mode[BL_LSB +: 2];
  assign rl      = read_latency(mode[CFG_LSB +: 3]);
  assign act_idx = {act_bank, col_base(act_addr[COL_W-1:0], bl)};

  always_comb begin : command_stage
    next_mux_wait = 1'b0;
    next_mux_cmd  = mux_cmd;
    next_mux_bank = mux_bank;
    next_mux_lo   = mux_lo;
    act           = CMD_NOP;
    act_bank      = link.bank;
    act_addr      = link.addr;
    if (mux_wait) begin
      // second edge: command pins are not looked at
      act      = mux_cmd;
      act_bank = mux_bank;
      act_addr = ADDR_W'({link.addr[MUX_ADDR_W-1:0], mux_lo});
    end else if (cmd != CMD_NOP && mode[MUX_BIT] && cmd != CMD_REFRESH) begin
      next_mux_wait = 1'b1;
      next_mux_cmd  = cmd;
      next_mux_bank = link.bank;
      next_mux_lo   = link.addr[MUX_ADDR_W-1:0];
    end else begin
      act = cmd;
    end
    next_mode = mode;
    if (act == CMD_MODE) begin
      next_mode = act_addr[MODE_W-1:0];
    end
  end

  always_ff @(posedge link.link_clk) begin
    if (reset) begin
      mode     <= '0;
      mux_wait <= 1'b0;
      mux_cmd  <= CMD_NOP;
      mux_bank <= '0;
      mux_lo   <= '0;
    end else begin
      mode     <= next_mode;
      mux_wait <= next_mux_wait;
      mux_cmd  <= next_mux_cmd;
      mux_bank <= next_mux_bank;
      mux_lo   <= next_mux_lo;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // latency pipelines: a slot at index k fires k+1 edges after the command
  logic                  rd_v [SLOTS];
  logic                  next_rd_v [SLOTS];
  logic [IDX_W-1:0]      rd_i [SLOTS];
  logic [IDX_W-1:0]      next_rd_i [SLOTS];
  logic                  wr_v [SLOTS];
  logic                  next_wr_v [SLOTS];
  logic [IDX_W-1:0]      wr_i [SLOTS];
  logic [IDX_W-1:0]      next_wr_i [SLOTS];
  logic [DATA_W-1:0]     mem [MEM_DEPTH];
  logic [DATA_W-1:0]     next_mem [MEM_DEPTH];
  logic [2:0]            rd_left;
  logic [2:0]            next_rd_left;
  logic [IDX_W-1:0]      rd_at;
  logic [IDX_W-1:0]      next_rd_at;
  logic [2:0]            wr_left;
  logic [2:0]            next_wr_left;
  logic [IDX_W-1:0]      wr_at;
  logic [IDX_W-1:0]      next_wr_at;
  logic [PAIR_W-1:0]     next_rdata;
  logic                  next_oe;
  logic [1:0]            next_flag;
  logic                  next_rterm;

  always_comb begin : pipeline_stage
    for (int i = 0; i < SLOTS - 1; i++) begin
      next_rd_v[i] = rd_v[i+1];
      next_rd_i[i] = rd_i[i+1];
      next_wr_v[i] = wr_v[i+1];
      next_wr_i[i] = wr_i[i+1];
    end
    next_rd_v[SLOTS-1] = 1'b0;
    next_rd_i[SLOTS-1] = '0;
    next_wr_v[SLOTS-1] = 1'b0;
    next_wr_i[SLOTS-1] = '0;
    if (act == CMD_READ) begin
      next_rd_v[rl - 4'h1] = 1'b1;
      next_rd_i[rl - 4'h1] = act_idx;
    end
    if (act == CMD_WRITE) begin
      next_wr_v[rl] = 1'b1;
      next_wr_i[rl] = act_idx;
    end
  end

  // no reformatting on a burst length change: old bursts simply misalign
  always_comb begin : write_stage
    logic [IDX_W-1:0] at;
    at           = wr_at;
    next_mem     = mem;
    next_wr_left = wr_left;
    next_wr_at   = wr_at;
    if (wr_v[0]) begin
      at           = wr_i[0];
      next_wr_left = burst_pairs(bl) - 3'h1;
    end else if (wr_left != 3'h0) begin
      next_wr_left = wr_left - 3'h1;
    end
    if (wr_v[0] || wr_left != 3'h0) begin
      next_wr_at = IDX_W'(at + 2'h2);
      if (!link.write_mask[0]) begin
        next_mem[at] = link.wdata[DATA_W-1:0];
      end
      if (!link.write_mask[1]) begin
        next_mem[IDX_W'(at + 1'b1)] = link.wdata[PAIR_W-1:DATA_W];
      end
    end
  end

  always_comb begin : read_stage
    logic [IDX_W-1:0] at;
    at           = rd_at;
    next_rd_left = rd_left;
    next_rd_at   = rd_at;
    next_oe      = 1'b0;
    next_rdata   = '0;
    if (rd_v[0]) begin
      at           = rd_i[0];
      next_oe      = 1'b1;
      next_rd_left = burst_pairs(bl) - 3'h1;
    end else if (rd_left != 3'h0) begin
      next_oe      = 1'b1;
      next_rd_left = rd_left - 3'h1;
    end
    if (next_oe) begin
      next_rd_at = IDX_W'(at + 2'h2);
      next_rdata = {mem[IDX_W'(at + 1'b1)], mem[at]};
    end
    // a read queued right behind keeps the flag high across the seam
    if (next_oe) begin
      next_flag = (next_rd_left == 3'h0 && !rd_v[1]) ? FLAG_LAST : FLAG_FULL;
    end else begin
      next_flag = rd_v[1] ? FLAG_LEAD : FLAG_OFF;
    end
    next_rterm = mode[TERM_BIT] && !next_oe;
  end

  always_ff @(posedge link.link_clk) begin
    mem <= next_mem;
  end

  always_ff @(posedge link.link_clk) begin
    if (reset) begin
      for (int i = 0; i < SLOTS; i++) begin
        rd_v[i] <= 1'b0;
        rd_i[i] <= '0;
        wr_v[i] <= 1'b0;
        wr_i[i] <= '0;
      end
      rd_left              <= '0;
      rd_at                <= '0;
      wr_left              <= '0;
      wr_at                <= '0;
      link.rdata           <= '0;
      link.rdata_oe        <= 1'b0;
      link.read_valid_flag <= FLAG_OFF;
      read_termination_on  <= 1'b0;
    end else begin
      rd_v                 <= next_rd_v;
      rd_i                 <= next_rd_i;
      wr_v                 <= next_wr_v;
      wr_i                 <= next_wr_i;
      rd_left              <= next_rd_left;
      rd_at                <= next_rd_at;
      wr_left              <= next_wr_left;
      wr_at                <= next_wr_at;
      link.rdata           <= next_rdata;
      link.rdata_oe        <= next_oe;
      link.read_valid_flag <= next_flag;
      read_termination_on  <= next_rterm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // loop lock timer and impedance calibration
  logic [CNT_W-1:0]      lock_cnt;
  logic [CNT_W-1:0]      next_lock_cnt;
  logic                  next_locked;
  logic [CNT_W-1:0]      cal_cnt;
  logic [CNT_W-1:0]      next_cal_cnt;
  logic [IMP_CODE_W-1:0] next_imp;
  logic [IMP_CODE_W-1:0] ref_meta;
  logic [IMP_CODE_W-1:0] ref_sync;

  always_comb begin : lock_and_cal
    next_lock_cnt = lock_cnt;
    next_locked   = loop_locked;
    if (act == CMD_MODE && !next_mode[LOOP_BIT]) begin
      next_lock_cnt = '0;
      next_locked   = 1'b0;
    end else if (act == CMD_MODE && !mode[LOOP_BIT]) begin
      next_lock_cnt = LOOP_LOCK_CYCLES;
      next_locked   = 1'b0;
    end else if (lock_cnt != '0) begin
      next_lock_cnt = lock_cnt - 1'b1;
      next_locked   = (lock_cnt == 11'h001);
    end
    // runs beside the data path, so updates never stall a burst
    next_cal_cnt = cal_cnt - 1'b1;
    next_imp     = impedance_code;
    if (cal_cnt == '0) begin
      next_cal_cnt = IMP_CAL_PERIOD;
      next_imp     = mode[IMP_BIT] ? ref_sync : IMP_NOMINAL_OHMS;
    end
  end

  always_ff @(posedge link.link_clk) begin
    ref_meta <= reference_code;
    ref_sync <= ref_meta;
    if (reset) begin
      lock_cnt             <= '0;
      loop_locked          <= 1'b0;
      cal_cnt              <= '0;
      impedance_code       <= IMP_NOMINAL_OHMS;
      mode_setting         <= '0;
      write_termination_on <= 1'b0;
    end else begin
      lock_cnt             <= next_lock_cnt;
      loop_locked          <= next_locked;
      cal_cnt              <= next_cal_cnt;
      impedance_code       <= next_imp;
      mode_setting         <= next_mode;
      write_termination_on <= next_mode[TERM_BIT];
    end
  end
endmodule : sio_dram_device

// *** hw/sio_dram_controller.sv ***
// memory controller end: one request at a time, drives link_clk as core_clk / 2
// assumes the device samples on link_clk rise; link pins change on its fall
module sio_dram_controller import sio_dram_pkg::*; (
  input  wire logic                          core_clk,
  input  wire logic                          reset,
  sio_link_if.controller                     link,
  input  wire logic                          req_valid,
  output logic                               req_ready,
  input  wire cmd_t                          req_kind,
  input  wire logic [BANK_W-1:0]             req_bank,
  input  wire logic [ADDR_W-1:0]             req_addr,
  input  wire logic [BURST_MAX*DATA_W-1:0]   req_wdata,
  input  wire logic [BURST_MAX-1:0]          req_wmask,
  output logic                               rsp_valid,
  output logic      [PAIR_W-1:0]             rsp_data
);
  typedef enum {S_IDLE, S_ADDR2, S_WAIT, S_WDATA} state_t;

  ////////////////////////////////////////////////////////////////////////////////
  state_t                      state, next_state;
  logic                        clk_q;
  logic [MODE_W-1:0]           ctl_mode, next_ctl_mode;
  logic [CNT_W-1:0]            cnt, next_cnt;
  logic [CNT_W-1:0]            lock, next_lock;
  logic                        pend_wr, next_pend_wr;
  logic [2:0]                  pairs, next_pairs;
  logic [MUX_ADDR_W-1:0]       hi, next_hi;
  logic [BURST_MAX*DATA_W-1:0] wbuf, next_wbuf;
  logic [BURST_MAX-1:0]        mbuf, next_mbuf;
  logic                        next_cs_n;
  logic [1:0]                  next_pins;
  logic [BANK_W-1:0]           next_bank;
  logic [ADDR_W-1:0]           next_addr, use_addr;
  logic [PAIR_W-1:0]           next_wdata;
  logic [1:0]                  next_mask;
  logic                        next_ready;
  logic                        tick;
  logic [LAT_W-1:0]            rl;
  logic [2:0]                  bp;

  assign tick = clk_q;
  assign rl   = read_latency(ctl_mode[CFG_LSB +: 3]);
  assign bp   = burst_pairs(ctl_mode[BL_LSB +: 2]);
  // upper mode bits forced low, bits above are don't care
  assign use_addr = (req_kind == CMD_MODE) ? ADDR_W'(req_addr[MODE_KEEP_W-1:0])
                                           : req_addr;

  always_comb begin : sequencer
    next_state = state;    next_ctl_mode = ctl_mode; next_cnt  = cnt;
    next_lock  = lock;     next_pend_wr  = pend_wr;  next_pairs = pairs;
    next_hi    = hi;       next_wbuf     = wbuf;     next_mbuf  = mbuf;
    next_cs_n  = link.cs_n; next_pins    = {link.we_n, link.ref_n};
    next_bank  = link.bank; next_addr    = link.addr;
    next_wdata = link.wdata; next_mask   = link.write_mask;
    if (tick) begin
      next_cs_n  = 1'b1;
      next_wdata = '0;
      next_mask  = 2'h3;
      if (lock != '0) next_lock = lock - 1'b1;
      unique case (state)
        S_IDLE: if (req_valid && req_ready) begin
          next_cs_n = 1'b0;
          next_pins = command_pins(req_kind);
          next_bank = req_bank;
          next_addr = use_addr;
          next_wbuf = req_wdata;
          next_mbuf = req_wmask;
          next_pairs = bp;
          next_pend_wr = (req_kind == CMD_WRITE);
          next_hi = MUX_ADDR_W'(use_addr >> MUX_ADDR_W);
          next_cnt = (req_kind == CMD_WRITE) ? CNT_W'(rl)
                   : (req_kind == CMD_READ) ? CNT_W'(rl) + CNT_W'(bp) + ROW_CYCLE_CYCLES
                   : ROW_CYCLE_CYCLES;
          if (req_kind == CMD_MODE) begin
            next_ctl_mode = use_addr[MODE_W-1:0];
            next_cnt = MODE_SET_RECOVERY_CYCLES;
            if (use_addr[LOOP_BIT] && !ctl_mode[LOOP_BIT]) next_lock = LOOP_LOCK_CYCLES;
          end
          if (ctl_mode[MUX_BIT] && req_kind != CMD_REFRESH) begin
            next_addr  = ADDR_W'(use_addr[MUX_ADDR_W-1:0]);
            next_state = S_ADDR2;
          end else begin
            next_state = S_WAIT;
          end
        end
        S_ADDR2: begin
          next_addr  = ADDR_W'(hi);
          next_state = S_WAIT;
        end
        S_WAIT: begin
          next_cnt = cnt - 1'b1;
          if (cnt <= 11'h001) next_state = pend_wr ? S_WDATA : S_IDLE;
        end
        S_WDATA: begin
          next_wdata = wbuf[PAIR_W-1:0];
          next_mask  = mbuf[1:0];
          next_wbuf  = wbuf >> PAIR_W;
          next_mbuf  = mbuf >> 2;
          next_pairs = pairs - 3'h1;
          if (pairs == 3'h1) begin
            next_pend_wr = 1'b0;
            next_cnt     = ROW_CYCLE_WR_RD_CYCLES;
            next_state   = S_WAIT;
          end
        end
      endcase
    end
    // reads wait out the loop lock; all commands stall to keep it simple
    next_ready = (next_state == S_IDLE) && !tick && (next_lock == '0);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= S_IDLE; clk_q <= 1'b0; ctl_mode <= '0; cnt <= '0; lock <= '0;
      pend_wr <= 1'b0; pairs <= '0; hi <= '0; wbuf <= '0; mbuf <= '0;
      link.cs_n <= 1'b1; link.we_n <= 1'b1; link.ref_n <= 1'b1;
      link.bank <= '0; link.addr <= '0; link.wdata <= '0; link.write_mask <= 2'h3;
      req_ready <= 1'b0; rsp_valid <= 1'b0; rsp_data <= '0;
    end else begin
      state <= next_state; clk_q <= !clk_q; ctl_mode <= next_ctl_mode;
      cnt <= next_cnt; lock <= next_lock; pend_wr <= next_pend_wr;
      pairs <= next_pairs; hi <= next_hi; wbuf <= next_wbuf; mbuf <= next_mbuf;
      link.cs_n <= next_cs_n; {link.we_n, link.ref_n} <= next_pins;
      link.bank <= next_bank; link.addr <= next_addr;
      link.wdata <= next_wdata; link.write_mask <= next_mask;
      req_ready <= next_ready;
      rsp_valid <= tick && link.rdata_oe;
      rsp_data  <= (tick && link.rdata_oe) ? link.rdata : rsp_data;
    end
  end

  assign link.link_clk = clk_q;
endmodule : sio_dram_controller

// *** dv/sio_dram_monitor.sv ***
// checker on the link between controller and dram device
// assumes checks key on the first command phase; one domain, the link clock
module sio_dram_monitor import sio_dram_pkg::*; (
  input logic               link_clk,
  input logic               reset,
  input logic               cs_n,
  input logic               we_n,
  input logic               ref_n,
  input logic [ADDR_W-1:0]  addr,
  input logic [PAIR_W-1:0]  rdata,
  input logic               rdata_oe,
  input logic [1:0]         read_valid_flag
);
  logic rd;
  logic md;
  logic rf;
  assign rd = !cs_n && we_n && ref_n;
  assign md = !cs_n && !we_n && !ref_n;
  assign rf = !cs_n && we_n && !ref_n;
  default clocking @(posedge link_clk); endclocking
  default disable iff (reset);
  //////////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!rdata_oe |-> rdata == 36'h0)
    else $error("read data not zero while released");
  a_flag_drive: assert property (rdata_oe |-> read_valid_flag[0])
    else $error("valid flag low while data driven");
  a_lead_data: assert property (read_valid_flag == FLAG_LEAD && !rdata_oe |=> rdata_oe)
    else $error("no data after leading flag half");
  a_flag_drop: assert property ($fell(rdata_oe) |->
    $past(read_valid_flag) == FLAG_LAST && read_valid_flag == FLAG_OFF)
    else $error("flag not dropped on last beat");
  a_read_lat: assert property (rd |-> ##[3:9] read_valid_flag[1])
    else $error("read data never announced");
  a_mode_high: assert property (md |-> addr[17:10] == 8'h00)
    else $error("mode set with upper bits set");
  a_mode_gap: assert property (md |=> cs_n [*5])
    else $error("command inside mode recovery");
  a_refresh_gap: assert property (rf |=> cs_n [*2])
    else $error("command inside row cycle");
endmodule : sio_dram_monitor

// *** dv/sio_dram_mode_and_burst_access_bench.sv ***
// bench: controller and device joined over the link, user side driven
// assumes the controller makes the link clock; device reset held until it runs
module sio_dram_mode_and_burst_access_bench import sio_dram_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic                        core_clk = 1'b0;
  logic                        reset = 1'b1;
  // link clock stands still in controller reset, so the device needs its own
  logic                        link_reset = 1'b1;
  logic                        req_valid = 1'b0;
  cmd_t                        req_kind = CMD_NOP;
  logic [ADDR_W-1:0]           req_addr = 20'h00000;
  logic [BURST_MAX*DATA_W-1:0] req_wdata = 144'h0;
  logic [BURST_MAX-1:0]        req_wmask = 8'h00;
  logic                        req_ready, rsp_valid, loop_locked, rterm, wterm;
  logic [PAIR_W-1:0]           rsp_data;
  logic [MODE_W-1:0]           mode_setting;
  logic [IMP_CODE_W-1:0]       impedance_code;
  int                          bad_count = 0;
  int                          samples_checked = 0;
  int                          waited;
  always #5 core_clk = ~core_clk;
  //////////////////////////////////////////////////////////////////////////////
  sio_link_if sio_link_if_i ();
  sio_dram_controller sio_dram_controller_i (.core_clk, .reset, .link(sio_link_if_i),
    .req_valid, .req_ready, .req_kind, .req_bank(3'h5), .req_addr, .req_wdata,
    .req_wmask, .rsp_valid, .rsp_data);
  sio_dram_device sio_dram_device_i (.link(sio_link_if_i), .reset(link_reset),
    .reference_code(8'h5A), .mode_setting, .loop_locked, .impedance_code,
    .read_termination_on(rterm), .write_termination_on(wterm));
  sio_dram_monitor sio_dram_monitor_i (.link_clk(sio_link_if_i.link_clk), .reset(link_reset),
    .cs_n(sio_link_if_i.cs_n), .we_n(sio_link_if_i.we_n), .ref_n(sio_link_if_i.ref_n),
    .addr(sio_link_if_i.addr), .rdata(sio_link_if_i.rdata),
    .rdata_oe(sio_link_if_i.rdata_oe), .read_valid_flag(sio_link_if_i.read_valid_flag));
  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [PAIR_W-1:0] got, input logic [PAIR_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // valid held until the edge that sees ready; lock wait needs a long bound
  task automatic issue(input cmd_t k, input logic [ADDR_W-1:0] a,
                       input logic [BURST_MAX*DATA_W-1:0] d, input logic [7:0] m);
    waited = 0;
    req_kind <= k;
    req_addr <= a;
    req_wdata <= d;
    req_wmask <= m;
    req_valid <= 1'b1;
    do begin
      @(posedge core_clk);
      waited++;
    end while (req_ready !== 1'b1 && waited < 4000);
    if (waited >= 4000) begin
      bad_count++;
      print_verdict();
    end
    req_valid <= 1'b0;
    // one idle edge so a following call never re-raises valid in this step
    @(posedge core_clk);
  endtask : issue
  task automatic pair(input logic [PAIR_W-1:0] e);
    int n;
    for (n = 0; n < 200 && rsp_valid !== 1'b1; n++) @(posedge core_clk);
    if (n >= 200) begin
      bad_count++;
      print_verdict();
    end
    chk(rsp_data, e);
    chk({35'h0, rterm}, 36'h0);
    @(posedge core_clk);
  endtask : pair
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    link_reset <= 1'b0;
    chk({28'h0, impedance_code}, 36'h32);
    issue(CMD_MODE, 20'h3FE08, 144'h0, 8'h00);
    issue(CMD_WRITE, 20'h00006, {72'h0, 18'hA3, 18'hA2, 18'hA1, 18'hA0}, 8'h00);
    chk({18'h0, mode_setting}, 36'h00208);
    chk({35'h0, wterm}, 36'h1);
    // masked words must keep the first burst
    issue(CMD_WRITE, 20'h00004, {72'h0, 18'hB3, 18'hB2, 18'hB1, 18'hB0}, 8'h05);
    issue(CMD_MODE, 20'h00288, 144'h0, 8'h00);
    issue(CMD_READ, 20'h00005, 144'h0, 8'h00);
    chk({35'h0, waited >= 2048}, 36'h1);
    pair({18'hB1, 18'hA0});
    pair({18'hB3, 18'hA2});
    chk({35'h0, loop_locked}, 36'h1);
    issue(CMD_REFRESH, 20'h00000, 144'h0, 8'h00);
    // split address, burst of two, read latency five
    issue(CMD_MODE, 20'h00222, 144'h0, 8'h00);
    issue(CMD_WRITE, 20'h00803, {108'h0, 18'hC1, 18'hC0}, 8'h00);
    chk({18'h0, mode_setting}, 36'h00222);
    issue(CMD_READ, 20'h00002, 144'h0, 8'h00);
    pair({18'hC1, 18'hC0});
    issue(CMD_MODE, 20'h00308, 144'h0, 8'h00);
    repeat (600) @(posedge core_clk);
    chk({28'h0, impedance_code}, 36'h5A);
    chk({35'h0, rterm}, 36'h1);
    print_verdict();
  end
endmodule : sio_dram_mode_and_burst_access_bench
